// [sar_adc_scan_sequencer.v]
// scan sequencer and control of a 12-bit successive-approximation converter
// Notes on behaviour
// [RULE1] each conversion is given at least 18 converter clocks at up to 18 MHz.
// [RULE2] each conversion yields 12 bits and the sequence reaches one megasample per second; the code takes 48 clocks per conversion plus acquisition.
// [RULE3] a setting picks supply, half supply, bandgap or an external pin as reference.
// [RULE4] the acquisition window length is programmable.
// [RULE5] eight channels are sequenced, extendable to sixteen.
// [RULE6] scan steps through enabled channels with no idle cycles between them.
// [RULE7] channel switching comes from the state machine or from firmware selection.
// [RULE8] each channel keeps its own result buffer.
// [RULE9] each channel has its own sample time applied when it is converted.
// [RULE10] each result is checked against low and high limits, flagging out-of-range at once.
// [RULE11] the temperature sensor can be selected as a conversion input.
// [RULE12] conversions run only in active and sleep power states.
// [RULE13] the sequencer can drive the opamp switch controls.
// [RULE14] after the last enabled channel the scan is marked done and continuous mode restarts.
// [RULE15] the out-of-range flag stays until cleared and records the channel.
`include "sar_seq_map.vh"
`default_nettype none
module sar_adc_scan_sequencer #(
   parameter NCH = 16,
   parameter CW = 4,
   parameter AQW = 8
) (
   input wire mclk_i,
   input wire rst_i,
   input wire enable_i,
   input wire [1:0] power_mode_i,
   input wire continuous_i,
   input wire start_i,
   input wire fw_select_i,
   input wire [CW-1:0] fw_channel_i,
   input wire fw_convert_i,
   input wire wide_mode_i,
   input wire [NCH-1:0] chan_enable_i,
   input wire temp_select_i,
   input wire [1:0] ref_select_i,
   input wire [NCH*AQW-1:0] sample_time_i,
   input wire [11:0] limit_low_i,
   input wire [11:0] limit_high_i,
   input wire range_clear_i,
   input wire [3:0] opamp_switch_cfg_i,
   input wire opamp_seq_ctrl_i,
   input wire [3:0] opamp_fw_switch_i,
   input wire comp_bit_i,
   input wire [CW-1:0] read_channel_i,
   input wire fifo_ready_i,
   output reg [CW-1:0] mux_channel_o,
   output reg temp_route_o,
   output reg [1:0] ref_route_o,
   output reg sample_o,
   output reg [11:0] dac_code_o,
   output reg [3:0] first_opamp_switch_o,
   output reg [3:0] second_opamp_switch_o,
   output reg [11:0] read_result_o,
   output reg busy_o,
   output reg scan_done_o,
   output reg range_irq_o,
   output reg [CW:0] range_channel_o,
   output reg fifo_valid_o,
   output reg [16:0] fifo_data_o,
   output reg fifo_overflow_o
);
   reg [11:0] result_q [0:NCH-1];
   reg [1:0] state_q;
   reg [AQW-1:0] acq_cnt_q;
   reg [5:0] conv_cnt_q;
   reg [3:0] bit_q;
   reg [11:0] sar_q;
   reg [CW-1:0] chan_q;
   reg cmp_meta_q;
   reg cmp_q;
   reg scan_run_q;
   reg is_last_q;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [16:0] fifo_out_data;
   reg push;
   integer i;

   wire [NCH-1:0] emask = wide_mode_i ? chan_enable_i : {8'h00, chan_enable_i[7:0]};
   // [RULE12] power gate
   wire pwr_ok = enable_i && (power_mode_i == `PWR_ACTIVE || power_mode_i == `PWR_SLEEP);

   // next enabled channel strictly after c, or first enabled if from_start; top bit set when none is found
   function [CW:0] next_chan;
      input [NCH-1:0] m;
      input [CW-1:0] c;
      input from_start;
      integer k;
      reg found;
      begin
         next_chan = {1'b1, {CW{1'b0}}};
         found = 1'b0;
         for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (m[k] && (from_start || k > c)) begin
               next_chan = {1'b0, k[CW-1:0]};
               found = 1'b1;
            end
         end
      end
   endfunction

   wire [CW:0] first_ch = next_chan(emask, {CW{1'b0}}, 1'b1);
   wire [CW:0] after_ch = next_chan(emask, chan_q, 1'b0);
   wire [AQW-1:0] acq_len = sample_time_i[chan_q*AQW +: AQW];
   wire [11:0] trial = sar_q | (12'h800 >> bit_q);
   wire [11:0] final_code = cmp_q ? trial : sar_q;
   // four clocks per bit: dac register, then the two comparator sync flops
   wire [5:0] conv_len = `CONV_CLOCKS;

   result_fifo #(.WIDTH(17), .DEPTH(16), .AW(4)) u_fifo (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i({temp_select_i, chan_q, final_code}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_ready_i),
      .out_data_o(fifo_out_data)
   );

   always @* begin
      push = (state_q == `ST_CONV) && (conv_cnt_q == conv_len - 6'h01);
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_meta_q <= 1'b0;
         cmp_q <= 1'b0;
      end else begin
         cmp_meta_q <= comp_bit_i;
         cmp_q <= cmp_meta_q;
      end
   end

   always @(posedge mclk_i) begin
      // [RULE8] per-channel buffer
      if (push && !temp_select_i)
         result_q[chan_q] <= final_code;
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= `ST_IDLE;
         acq_cnt_q <= {AQW{1'b0}};
         conv_cnt_q <= 6'h00;
         bit_q <= 4'h0;
         sar_q <= 12'h000;
         chan_q <= {CW{1'b0}};
         scan_run_q <= 1'b0;
         is_last_q <= 1'b0;
         mux_channel_o <= {CW{1'b0}};
         temp_route_o <= 1'b0;
         ref_route_o <= `REF_SUPPLY;
         sample_o <= 1'b0;
         dac_code_o <= 12'h000;
         first_opamp_switch_o <= 4'h0;
         second_opamp_switch_o <= 4'h0;
         read_result_o <= 12'h000;
         busy_o <= 1'b0;
         scan_done_o <= 1'b0;
         range_irq_o <= 1'b0;
         range_channel_o <= {(CW+1){1'b0}};
         fifo_valid_o <= 1'b0;
         fifo_data_o <= 17'h00000;
         fifo_overflow_o <= 1'b0;
      end else begin
         scan_done_o <= 1'b0;
         fifo_valid_o <= fifo_out_valid;
         fifo_data_o <= fifo_out_data;
         read_result_o <= result_q[read_channel_i];
         // [RULE3] reference select
         ref_route_o <= ref_select_i;
         // [RULE11] temperature input
         temp_route_o <= temp_select_i;
         mux_channel_o <= chan_q;
         // [RULE13] opamp switch drive
         if (opamp_seq_ctrl_i) begin
            first_opamp_switch_o <= (state_q == `ST_ACQ) ? opamp_switch_cfg_i : 4'h0;
            second_opamp_switch_o <= (state_q == `ST_ACQ) ? opamp_switch_cfg_i : 4'h0;
         end else begin
            first_opamp_switch_o <= opamp_fw_switch_i;
            second_opamp_switch_o <= opamp_fw_switch_i;
         end
         // overflow drops a result; per-channel buffer still holds it unless it is a temperature result
         if (push && !fifo_in_ready)
            fifo_overflow_o <= 1'b1;
         else if (range_clear_i)
            fifo_overflow_o <= 1'b0;
         // [RULE15] sticky flag, set wins over clear
         if (push && (final_code < limit_low_i || final_code > limit_high_i)) begin
            // [RULE10] window compare
            range_irq_o <= 1'b1;
            range_channel_o <= {temp_select_i, chan_q};
         end else if (range_clear_i) begin
            range_irq_o <= 1'b0;
         end
         sample_o <= (state_q == `ST_ACQ);
         dac_code_o <= trial;
         busy_o <= (state_q != `ST_IDLE);
         case (state_q)
            `ST_IDLE: begin
               // [RULE7] firmware or sequencer selects channel
               if (pwr_ok && fw_select_i && fw_convert_i) begin
                  chan_q <= fw_channel_i;
                  scan_run_q <= 1'b0;
                  acq_cnt_q <= {AQW{1'b0}};
                  state_q <= `ST_ACQ;
               end else if (pwr_ok && !fw_select_i && start_i && !first_ch[CW]) begin
                  chan_q <= first_ch[CW-1:0];
                  scan_run_q <= 1'b1;
                  acq_cnt_q <= {AQW{1'b0}};
                  state_q <= `ST_ACQ;
               end
            end
            `ST_ACQ: begin
               // [RULE9] per-channel sample time
               if (!pwr_ok) begin
                  state_q <= `ST_IDLE;
               end else if (acq_cnt_q + 1'b1 >= acq_len) begin
                  // [RULE4] programmable aperture
                  state_q <= `ST_CONV;
                  conv_cnt_q <= 6'h00;
                  bit_q <= 4'h0;
                  sar_q <= 12'h000;
                  is_last_q <= after_ch[CW];
               end else begin
                  acq_cnt_q <= acq_cnt_q + 1'b1;
               end
            end
            `ST_CONV: begin
               // [RULE1] 48 clocks per conversion
               conv_cnt_q <= conv_cnt_q + 6'h01;
               // [RULE2] twelve bit trials
               // decide only once the synced comparator reflects the current trial
               if (bit_q < 4'hC && conv_cnt_q[1:0] == 2'h3) begin
                  if (cmp_q)
                     sar_q <= trial;
                  bit_q <= bit_q + 4'h1;
               end
               if (!pwr_ok) begin
                  state_q <= `ST_IDLE;
               end else if (push) begin
                  if (!scan_run_q) begin
                     state_q <= `ST_IDLE;
                  end else if (!is_last_q) begin
                     // [RULE6] no idle between channels
                     chan_q <= after_ch[CW-1:0];
                     acq_cnt_q <= {AQW{1'b0}};
                     state_q <= `ST_ACQ;
                  end else begin
                     state_q <= `ST_DONE;
                  end
               end
            end
            `ST_DONE: begin
               // [RULE14] scan end and restart
               scan_done_o <= 1'b1;
               if (continuous_i && pwr_ok && !first_ch[CW]) begin
                  // [RULE5] eight or sixteen inputs
                  chan_q <= first_ch[CW-1:0];
                  acq_cnt_q <= {AQW{1'b0}};
                  state_q <= `ST_ACQ;
               end else begin
                  scan_run_q <= 1'b0;
                  state_q <= `ST_IDLE;
               end
            end
            default: state_q <= `ST_IDLE;
         endcase
      end
   end
endmodule // sar_adc_scan_sequencer
`default_nettype wire

// [sar_seq_map.vh]
// constants for the converter scan sequencer
`ifndef SAR_SEQ_MAP_VH
`define SAR_SEQ_MAP_VH
`define CONV_CLOCKS 6'h30
`define ACQ_DEFAULT 8'h04
`define REF_SUPPLY 2'h0
`define REF_HALF_SUPPLY 2'h1
`define REF_BANDGAP 2'h2
`define REF_EXTERNAL 2'h3
`define TEMP_CHANNEL 5'h10
`define PWR_ACTIVE 2'h0
`define PWR_SLEEP 2'h1
`define ST_IDLE 2'h0
`define ST_ACQ 2'h1
`define ST_CONV 2'h2
`define ST_DONE 2'h3
`endif

// [result_fifo.v]
// parameterised result fifo with valid and ready on both sides
`default_nettype none
module result_fifo #(
   parameter WIDTH = 17,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire mclk_i,
   input wire rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   wire full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
   wire empty = (wr_q == rd_q);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rd_q[AW-1:0]];
   always @(posedge mclk_i) begin
      if (in_valid_i && !full)
         mem[wr_q[AW-1:0]] <= in_data_i;
   end
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (in_valid_i && !full)
            wr_q <= wr_q + 1'b1;
         if (out_ready_i && !empty)
            rd_q <= rd_q + 1'b1;
      end
   end
endmodule // result_fifo
`default_nettype wire

// [sar_adc_scan_sequencer_properties.sv]
// port checker for the converter scan sequencer
`default_nettype none
module sar_seq_checker (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [1:0] power_mode_i,
   input wire logic range_clear_i,
   input wire logic opamp_seq_ctrl_i,
   input wire logic [3:0] opamp_fw_switch_i,
   input wire logic [3:0] mux_channel_o,
   input wire logic [3:0] first_opamp_switch_o,
   input wire logic sample_o,
   input wire logic busy_o,
   input wire logic scan_done_o,
   input wire logic range_irq_o,
   input wire logic fifo_overflow_o
);
   logic [7:0] low_q;
   // low_q saturates so a long idle spell cannot wrap into a false short gap
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) low_q <= 8'h00;
      else if (sample_o) low_q <= 8'h00;
      else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence acq_again;
      $rose(sample_o) && $past(busy_o);
   endsequence
   sequence fw_steady;
      !opamp_seq_ctrl_i && !$past(opamp_seq_ctrl_i) && !$past(rst_i) && $stable(opamp_fw_switch_i);
   endsequence
   AST_CONV_GAP: assert property (acq_again |-> low_q >= 8'h12) else $error("short conversion");
   AST_POWER_GATE: assert property ($rose(busy_o) |-> $past(power_mode_i) <= 2'h1)
      else $error("start in stop mode");
   AST_DONE_PULSE: assert property (scan_done_o |=> !scan_done_o) else $error("done too long");
   AST_IRQ_HOLD: assert property (range_irq_o && !range_clear_i |=> range_irq_o)
      else $error("range flag lost");
   AST_IDLE_QUIET: assert property (!busy_o |-> !sample_o) else $error("sampling while idle");
   AST_ACQ_CHANNEL: assert property (sample_o && $past(sample_o) |-> $stable(mux_channel_o))
      else $error("channel moved in acquisition");
   AST_OPAMP_FW: assert property (fw_steady |-> first_opamp_switch_o == opamp_fw_switch_i)
      else $error("opamp switch mismatch");
   AST_OVF_HOLD: assert property (fifo_overflow_o && !range_clear_i |=> fifo_overflow_o)
      else $error("overflow flag lost");
endmodule // sar_seq_checker
bind sar_adc_scan_sequencer sar_seq_checker chk_u (.mclk_i, .rst_i, .power_mode_i, .range_clear_i,
   .opamp_seq_ctrl_i, .opamp_fw_switch_i, .mux_channel_o, .first_opamp_switch_o, .sample_o,
   .busy_o, .scan_done_o, .range_irq_o, .fifo_overflow_o);
`default_nettype wire

// [conv_core_model.sv]
// behavioural mux and comparator standing in for the analog core
`default_nettype none
module conv_core_model (
   input wire logic mclk_i,
   input wire logic [3:0] mux_channel_i,
   input wire logic temp_route_i,
   input wire logic [11:0] dac_code_i,
   output var logic comp_bit_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] level;
   assign level = temp_route_i ? 12'h7C3 : {mux_channel_i, 8'hA5};
   // trial comparison
   // comparator is analog: it follows the dac code with no clock
   assign comp_bit_o = (level >= dac_code_i);
endmodule // conv_core_model
`default_nettype wire

// [sar_adc_scan_sequencer_tb_top.sv]
// testbench for the converter scan sequencer
`default_nettype none
module sar_adc_scan_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b1, continuous_i = 1'b0, start_i = 1'b0;
   logic fw_select_i = 1'b0, fw_convert_i = 1'b0, wide_mode_i = 1'b0, temp_select_i = 1'b0;
   logic range_clear_i = 1'b0, opamp_seq_ctrl_i = 1'b0, fifo_ready_i = 1'b0, comp_bit_i;
   logic [1:0] power_mode_i = 2'h0, ref_select_i = 2'h0;
   logic [3:0] fw_channel_i = 4'h0, read_channel_i = 4'h0, opamp_switch_cfg_i = 4'h5;
   logic [3:0] opamp_fw_switch_i = 4'h0, mux_channel_o, first_opamp_switch_o, second_opamp_switch_o;
   logic [15:0] chan_enable_i = 16'h0000;
   logic [127:0] sample_time_i = {16{8'h04}};
   logic [11:0] limit_low_i = 12'h000, limit_high_i = 12'hFFF, dac_code_o, read_result_o;
   logic temp_route_o, sample_o, busy_o, scan_done_o, range_irq_o, fifo_valid_o, fifo_overflow_o;
   logic [1:0] ref_route_o;
   logic [4:0] range_channel_o;
   logic [16:0] fifo_data_o, first;
   logic seen_done;
   int fails = 0, compares = 0, cyc = 0, busy_n, n;
   logic [1:0] ref_seen;
   always #50 mclk_i = ~mclk_i;
   sar_adc_scan_sequencer dut_u (.mclk_i, .rst_i, .enable_i, .power_mode_i, .continuous_i,
      .start_i, .fw_select_i, .fw_channel_i, .fw_convert_i, .wide_mode_i, .chan_enable_i,
      .temp_select_i, .ref_select_i, .sample_time_i, .limit_low_i, .limit_high_i, .range_clear_i,
      .opamp_switch_cfg_i, .opamp_seq_ctrl_i, .opamp_fw_switch_i, .comp_bit_i, .read_channel_i,
      .fifo_ready_i, .mux_channel_o, .temp_route_o, .ref_route_o, .sample_o, .dac_code_o,
      .first_opamp_switch_o, .second_opamp_switch_o, .read_result_o, .busy_o, .scan_done_o,
      .range_irq_o, .range_channel_o, .fifo_valid_o, .fifo_data_o, .fifo_overflow_o);
   conv_core_model core_u (.mclk_i, .mux_channel_i(mux_channel_o), .temp_route_i(temp_route_o),
      .dac_code_i(dac_code_o), .comp_bit_o(comp_bit_i));
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one start or firmware conversion, then wait for idle under a bound
   task automatic go(input logic fw);
      int k;
      @(posedge mclk_i);
      if (fw) fw_convert_i <= 1'b1;
      else start_i <= 1'b1;
      @(posedge mclk_i);
      fw_convert_i <= 1'b0;
      start_i <= 1'b0;
      seen_done = 1'b0;
      k = 0;
      repeat (3) @(negedge mclk_i);
      ref_seen = ref_route_o;
      while (busy_o === 1'b1 && k < 3000) begin
         @(negedge mclk_i);
         seen_done |= scan_done_o;
         k++;
      end
      @(negedge mclk_i);
      seen_done |= scan_done_o;
      busy_n = k;
      check(k < 3000, 1'b1);
   endtask
   task automatic rd(input logic [3:0] c, input logic [11:0] e);
      @(posedge mclk_i);
      read_channel_i <= c;
      repeat (2) @(negedge mclk_i);
      check(read_result_o, e);
   endtask
   task automatic drain;
      n = 0;
      repeat (40) begin
         @(negedge mclk_i);
         if (fifo_valid_o === 1'b1) begin
            if (n == 0) first = fifo_data_o;
            n++;
            @(posedge mclk_i) fifo_ready_i <= 1'b1;
            @(posedge mclk_i) fifo_ready_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
         end
      end
   endtask
   task automatic test_scan;
      // channel 9 is masked off by narrow mode, so two conversions only
      chan_enable_i <= 16'h0209;
      go(1'b0);
      check(seen_done, 1'b1);
      check(busy_n + 3 >= 44, 1'b1);
      check(busy_n <= 120, 1'b1);
      check(second_opamp_switch_o, 4'hA);
      rd(4'h0, 12'h0A5);
      rd(4'h3, 12'h3A5);
      $display("scan test done");
   endtask
   task automatic test_wide;
      wide_mode_i <= 1'b1;
      chan_enable_i <= 16'h8100;
      sample_time_i[127:120] <= 8'h20;
      go(1'b0);
      check(busy_n + 3 >= 132, 1'b1);
      check(busy_n <= 150, 1'b1);
      rd(4'hF, 12'hFA5);
      rd(4'h8, 12'h8A5);
      $display("wide test done");
   endtask
   task automatic test_range;
      limit_low_i <= 12'h200;
      limit_high_i <= 12'h2FF;
      chan_enable_i <= 16'h0004;
      go(1'b0);
      check(range_irq_o, 1'b0);
      chan_enable_i <= 16'h0010;
      go(1'b0);
      check(range_irq_o, 1'b1);
      check(range_channel_o, 5'h04);
      @(posedge mclk_i) range_clear_i <= 1'b1;
      @(posedge mclk_i) range_clear_i <= 1'b0;
      repeat (2) @(negedge mclk_i);
      check(range_irq_o, 1'b0);
      $display("range test done");
   endtask
   task automatic test_power_fw;
      power_mode_i <= 2'h2;
      go(1'b0);
      check(busy_n, 0);
      power_mode_i <= 2'h1;
      fw_select_i <= 1'b1;
      fw_channel_i <= 4'h6;
      go(1'b1);
      rd(4'h6, 12'h6A5);
      for (int r = 0; r < 4; r++) begin
         ref_select_i <= r[1:0];
         go(1'b1);
         check(ref_seen, r[1:0]);
      end
      @(posedge mclk_i) range_clear_i <= 1'b1;
      @(posedge mclk_i) range_clear_i <= 1'b0;
      repeat (2) @(negedge mclk_i);
      check(range_irq_o, 1'b0);
      fw_channel_i <= 4'h0;
      temp_select_i <= 1'b1;
      limit_low_i <= 12'h000;
      limit_high_i <= 12'h7C2;
      go(1'b1);
      check(range_irq_o, 1'b1);
      check(range_channel_o, 5'h10);
      temp_select_i <= 1'b0;
      limit_high_i <= 12'hFFF;
      $display("power and firmware test done");
   endtask
   task automatic test_fifo;
      drain();
      @(posedge mclk_i) range_clear_i <= 1'b1;
      @(posedge mclk_i) range_clear_i <= 1'b0;
      opamp_seq_ctrl_i <= 1'b1;
      fw_select_i <= 1'b0;
      chan_enable_i <= 16'hFFFF;
      go(1'b0);
      check(fifo_overflow_o, 1'b0);
      fw_select_i <= 1'b1;
      go(1'b1);
      check(fifo_overflow_o, 1'b1);
      drain();
      check(n, 16);
      check(first, 17'h000A5);
      $display("fifo test done");
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      opamp_fw_switch_i <= 4'hA;
      test_scan();
      test_wide();
      test_range();
      test_power_fw();
      test_fifo();
      end_sim();
   end
endmodule // sar_adc_scan_sequencer_tb_top
`default_nettype wire
